// File: test/asc_scan_control_properties.sv
/*
 * Checker for the converter scan control: bus timing, pulse widths and
 * the causes of conversion requests, stores and interrupts.
 * Assumes it is bound to asc_scan_control and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_scan_control_checker (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // Bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Converter side.
    input wire logic convTrigger,
    input wire logic convDone,
    input wire logic convStart,
    input wire asc_pkg::asc_conv_req_s convReq,
    input wire asc_pkg::asc_result_s resultOut,
    input wire logic scanIrq
);
    import asc_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    wait_state_a: assert property (hsel && htrans[1] && hready
        |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
    ready_idle_a: assert property (hreadyout && !(hsel && htrans[1])
        |=> hreadyout) else $error("hreadyout dropped while idle");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("convStart longer than one cycle");
    start_cause_a: assert property (convStart |->
        $past(convTrigger, 2) || $past(convDone, 2))
        else $error("convStart without cause");
    req_hold_a: assert property (!convStart |-> $stable(convReq))
        else $error("convReq changed without convStart");
    store_cause_a: assert property (resultOut.we |-> $past(convDone))
        else $error("store without convDone");
    irq_pulse_a: assert property (scanIrq |=> !scanIrq)
        else $error("scanIrq longer than one cycle");
    irq_cause_a: assert property (scanIrq |-> $past(convDone)
        || $past(convDone, 2) || $past(convDone, 3))
        else $error("scanIrq without conversion");
endmodule

bind asc_scan_control asc_scan_control_checker i_chk (
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .convTrigger(convTrigger), .convDone(convDone),
    .convStart(convStart), .convReq(convReq), .resultOut(resultOut),
    .scanIrq(scanIrq)
);

`default_nettype wire

// File: test/tb_top.sv
/*
 * Self-checking bench for the converter scan control. Registers are reached
 * through an AHB-Lite master task; the bench plays the converter core.
 * Assumes one slave, so hready is the slave's own hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import asc_pkg::*;

    logic core_clk, srst, hsel, hwrite, hready, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic convTrigger, convDone, convStart, scanIrq;
    logic [11:0] convResult;
    asc_conv_req_s convReq;
    asc_result_s resultOut;
    asc_aux_s auxReq;
    int nFail, checksDone;

    assign hready = hreadyout;

    asc_scan_control i_dut (
        .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .convTrigger(convTrigger), .convDone(convDone),
        .convResult(convResult), .convStart(convStart),
        .convReq(convReq), .resultOut(resultOut), .scanIrq(scanIrq),
        .auxReq(auxReq)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic endOfTest;
        if (nFail == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits mid-cycle for a level; registered outputs hold it to the edge.
    task automatic waitHigh(ref logic sig, input string what);
        int i;
        @(negedge core_clk);
        for (i = 0; i < 50 && sig !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (sig !== 1'b1) begin
            chk(what, 32'h0, 32'h1);
            endOfTest();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        waitHigh(hreadyout, "address phase ready");
        @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        waitHigh(hreadyout, "data phase ready");
        r = hrdata;
        @(posedge core_clk);
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdChk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk(what, rd, exp);
    endtask

    // Plays one conversion of the core and checks the request and store.
    task automatic convert(input logic [4:0] ch, input logic [11:0] res,
                           input logic store, input logic irq);
        waitHigh(convStart, "convStart");
        chk("convReq", {19'h0, convReq},
            {19'h0, ch, 3'h0, 3'h4, 2'h0});
        @(posedge core_clk);
        convDone <= 1'b1;
        convResult <= res;
        @(posedge core_clk);
        convDone <= 1'b0;
        @(negedge core_clk);
        chk("store", {31'h0, resultOut.we}, {31'h0, store});
        chk("match irq", {31'h0, scanIrq}, {31'h0, irq});
        if (store) begin
            chk("store data", {20'h0, resultOut.data}, {20'h0, res});
            chk("store ch", {27'h0, resultOut.channel}, {27'h0, ch});
        end
    endtask

    task automatic regsReset;
        rdChk("con5 reset", ADDR_CON5, 32'h0);
        rdChk("sample reset", ADDR_SAMPLE, 32'h0);
        rdChk("hit low reset", ADDR_HIT_LOW, 32'h0);
        rdChk("scan high reset", ADDR_SCAN_HIGH, 32'h0);
    endtask

    task automatic regsMask;
        wr(ADDR_CON5, 32'h0000FFFF);
        rdChk("con5 mask", ADDR_CON5, 32'h0000FB0F);
        wr(ADDR_SAMPLE, 32'h0000FFFF);
        rdChk("sample all", ADDR_SAMPLE, 32'h0000FFFF);
        wr(ADDR_SCAN_HIGH, 32'h0000FFFF);
        rdChk("scan high", ADDR_SCAN_HIGH, 32'h00007C03);
        wr(ADDR_SCAN_LOW, 32'h0000FFFF);
        rdChk("scan low", ADDR_SCAN_LOW, 32'h0000FFFF);
        wr(ADDR_HIT_HIGH, 32'h0000FFFF);
        rdChk("hit high ones", ADDR_HIT_HIGH, 32'h0);
        rdChk("unmapped", 8'h40, 32'h0);
        wr(ADDR_CON5, 32'h0);
        wr(ADDR_SAMPLE, 32'h0);
        wr(ADDR_SCAN_HIGH, 32'h0);
    endtask

    // Scan of channels 1 and 3 in less-than mode, then greater-than.
    task automatic scanCompare;
        wr(8'h84, 32'h00000800);
        wr(8'h8C, 32'h00000100);
        wr(ADDR_SCAN_LOW, 32'h0000000A);
        wr(ADDR_CON5, 32'h0000A900);
        wr(ADDR_LINK_CFG, 32'h00000001);
        wr(8'h84, 32'h00000FFF);
        rdChk("buffer locked", 8'h84, 32'h00000800);
        chk("regulator", {31'h0, auxReq.regulator}, 32'h1);
        chk("bandgap", {31'h0, auxReq.bandgap}, 32'h0);
        chk("charge unit", {31'h0, auxReq.chargeUnit}, 32'h1);
        @(posedge core_clk);
        convTrigger <= 1'b1;
        @(posedge core_clk);
        convTrigger <= 1'b0;
        convert(5'h01, 12'h400, 1'b1, 1'b0);
        convert(5'h03, 12'h200, 1'b1, 1'b0);
        waitHigh(scanIrq, "scan done irq");
        rdChk("hit less", ADDR_HIT_LOW, 32'h00000002);
        rdChk("buffer stored", 8'h8C, 32'h00000200);
        wr(ADDR_HIT_LOW, 32'h0);
        rdChk("hit cleared", ADDR_HIT_LOW, 32'h0);
        wr(ADDR_CON5, 32'h0000C209);
        @(posedge core_clk);
        convTrigger <= 1'b1;
        @(posedge core_clk);
        convTrigger <= 1'b0;
        convert(5'h01, 12'h900, 1'b0, 1'b1);
        convert(5'h03, 12'h300, 1'b0, 1'b1);
        rdChk("hit greater", ADDR_HIT_LOW, 32'h0000000A);
        chk("low power", {31'h0, auxReq.lowPower}, 32'h1);
    endtask

    initial begin
        nFail = 0;
        checksDone = 0;
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwrite = 1'b0;
        hwdata = 32'h0;
        convTrigger = 1'b0;
        convDone = 1'b0;
        convResult = 12'h000;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        regsReset();
        regsMask();
        scanCompare();
        endOfTest();
    end
endmodule

`default_nettype wire

// File: verilog/asc_pkg.sv
/*
 * Shared constants and types for the converter scan and threshold control.
 * Assumes a 32-bit AHB-Lite register bus and a converter core on the same
 * clock that takes one conversion request at a time.
 */
package asc_pkg;

    // Register byte offsets within the slave's window.
    localparam logic [7:0] ADDR_CON5 = 8'h00;
    localparam logic [7:0] ADDR_SAMPLE = 8'h04;
    localparam logic [7:0] ADDR_HIT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_HIT_LOW = 8'h0C;
    localparam logic [7:0] ADDR_SCAN_HIGH = 8'h10;
    localparam logic [7:0] ADDR_SCAN_LOW = 8'h14;
    localparam logic [7:0] ADDR_LINK_CFG = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    // Buffer words 0 to 31 sit at 0x80 to 0xFC.
    localparam int BUF_SPACE_BIT = 7;

    // Fifth control register fields.
    localparam int SCAN_EN_BIT = 15;
    localparam int LOW_POWER_BIT = 14;
    localparam int CHARGE_REQ_BIT = 13;
    localparam int BANDGAP_REQ_BIT = 12;
    localparam int REGULATOR_REQ_BIT = 11;
    localparam int INT_MODE_LSB = 8;
    localparam int WRITE_MODE_LSB = 2;
    localparam int COMPARE_MODE_LSB = 0;
    localparam logic [15:0] CON5_WRITABLE = 16'hFB0F;

    // Sample select register fields.
    localparam int B_NEG_LSB = 13;
    localparam int B_POS_LSB = 8;
    localparam int A_NEG_LSB = 5;
    localparam int A_POS_LSB = 0;

    // Link configuration register fields.
    localparam int CONV_ON_BIT = 0;
    localparam int ALT_SEL_BIT = 1;
    localparam int PREF_LSB = 2;

    // Implemented channel masks.
    localparam logic [31:0] HIT_IMPL = 32'h0003FFFF;
    localparam logic [31:0] SCAN_IMPL = 32'h7C03FFFF;

    // Reset values.
    localparam logic [15:0] CON5_RESET = 16'h0000;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;
    localparam logic [31:0] HIT_RESET = 32'h00000000;
    localparam logic [31:0] SCAN_RESET = 32'h00000000;

    // Input select codes.
    localparam logic [2:0] NEG_GROUND = 3'h0;
    localparam logic [4:0] POS_LAST_INPUT = 5'h0F;
    localparam logic [4:0] POS_BANDGAP = 5'h1A;
    localparam logic [4:0] POS_LOWER_GUARD = 5'h1B;
    localparam logic [4:0] POS_UPPER_GUARD = 5'h1C;

    typedef enum logic [1:0] {
        CMP_LESS = 2'h0,
        CMP_GREATER = 2'h1,
        CMP_INSIDE = 2'h2,
        CMP_OUTSIDE = 2'h3
    } asc_cmp_e;

    typedef enum logic [1:0] {
        WR_LEGACY = 2'h0,
        WR_SAVE_MATCH = 2'h1,
        WR_COMPARE_ONLY = 2'h2,
        WR_RESERVED = 2'h3
    } asc_wr_e;

    typedef enum logic [1:0] {
        INT_NONE = 2'h0,
        INT_SEQ_DONE = 2'h1,
        INT_MATCH = 2'h2,
        INT_MATCH_AND_DONE = 2'h3
    } asc_int_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ISSUE = 4'h2,
        ST_WAIT = 4'h4,
        ST_FINISH = 4'h8
    } asc_fsm_e;

    // One conversion request to the converter core.
    typedef struct packed {
        logic [4:0] posSel;
        logic [2:0] negSel;
        logic negGround;
        logic posFloating;
        logic posBandgap;
        logic [1:0] refSel;
    } asc_conv_req_s;

    // Result store towards the result buffer consumer.
    typedef struct packed {
        logic we;
        logic [4:0] channel;
        logic [11:0] data;
    } asc_result_s;

    // Auxiliary analog block requests.
    typedef struct packed {
        logic chargeUnit;
        logic bandgap;
        logic regulator;
        logic lowPower;
    } asc_aux_s;

endpackage

// File: verilog/asc_scan_control.sv
/*
 * Scan and threshold-detect control of the converter, with its registers
 * and threshold buffer behind an AHB-Lite slave. Assumes the converter core
 * runs on core_clk, takes convStart as a one-cycle pulse and returns
 * convDone with convResult on the same clock; convTrigger is the sample
 * clock source event, also on core_clk.
 */
// Operation
// - auto-scan enable bit starts automatic channel scanning
// - low-power return bit drops power after scan
// - charge-unit request enables unit while active
// - band-gap request enables reference while active
// - regulator request enables regulator while active
// - interrupt mode selects none, done, match, both
// - write mode 10 discards results, still interrupts
// - write mode 01 stores result only on match
// - write mode 00 stores every result; 11 reserved
// - compare 11 matches outside buffer pair window
// - compare 10 matches inside buffer pair window
// - compare 01 matches result above threshold
// - compare 00 matches result below threshold
// - negative select 000 ground, else inputs 0-6
// - positive codes 0-15 inputs, 10000/10001 floating
// - guardband rails, band-gap codes; 11111 unused
// - sample A selects decode like sample B
// - band-gap input level follows reference config
// - eighteen hit bits; compare 11 also on store
// - scan-select bits include channels 0-17, 26-30
// - unimplemented hit and scan bits read zero
// - control five bits 10, 7-4 read zero
// - buffer writes allowed only while converter off
// - alternate select toggles sample A and B
`timescale 1ns/1ps
`default_nettype none

module asc_scan_control (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter core.
    input wire logic convTrigger,
    input wire logic convDone,
    input wire logic [11:0] convResult,
    output logic convStart,
    output asc_pkg::asc_conv_req_s convReq,
    // Result store, scan interrupt and auxiliary requests.
    output asc_pkg::asc_result_s resultOut,
    output logic scanIrq,
    output asc_pkg::asc_aux_s auxReq
);
    import asc_pkg::*;

    typedef struct packed {
        logic [15:0] con5;
        logic [15:0] sample;
        logic [31:0] hit;
        logic [31:0] scan;
        logic convOn;
        logic altSel;
        logic [1:0] pref;
        logic [31:0][11:0] buffer;
        asc_fsm_e fsm;
        logic [4:0] chan;
        logic [4:0] posSel;
        logic [2:0] negSel;
        logic autoRun;
        logic altPhase;
        logic scanMatch;
        logic busPend;
        logic busWrite;
        logic [7:0] busAddr;
        logic hreadyout;
        logic [31:0] hrdata;
        logic convStart;
        asc_conv_req_s convReq;
        asc_result_s result;
        logic irq;
        asc_aux_s aux;
    } asc_state_s;

    asc_state_s s;
    asc_state_s next_s;

    // Finds the lowest set bit of mask at or above start; bit 5 is found.
    function automatic logic [5:0] nextScanChan(input logic [31:0] mask,
                                                input logic [5:0] start);
        logic found;
        logic [4:0] idx;
        found = 1'b0;
        idx = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (!found && (6'(i) >= start) && mask[i]) begin
                found = 1'b1;
                idx = 5'(i);
            end
        end
        return {found, idx};
    endfunction

    logic [31:0] rdWord;
    logic [5:0] firstChan;
    logic [5:0] followChan;
    logic [4:0] pairLow;
    logic [4:0] pairHigh;
    logic [11:0] thrLow;
    logic [11:0] thrHigh;
    logic match;
    logic store;
    logic [31:0] hitSet;
    logic [31:0] hitKeep;
    logic active;
    asc_cmp_e cmpMode;
    asc_wr_e wrMode;
    asc_int_e intMode;

    assign cmpMode = asc_cmp_e'(s.con5[COMPARE_MODE_LSB +: 2]);
    assign wrMode = asc_wr_e'(s.con5[WRITE_MODE_LSB +: 2]);
    assign intMode = asc_int_e'(s.con5[INT_MODE_LSB +: 2]);
    assign firstChan = nextScanChan(s.scan, 6'h00);
    assign followChan = nextScanChan(s.scan, {1'b0, s.chan} + 6'h01);

    // A window uses the even and odd buffer words of the channel's pair.
    assign pairLow = {s.chan[4:1], 1'b0};
    assign pairHigh = {s.chan[4:1], 1'b1};
    assign thrLow = s.buffer[pairLow];
    assign thrHigh = s.buffer[pairHigh];

    always_comb begin
        case (cmpMode)
            CMP_LESS: match = convResult < s.buffer[s.chan];
            CMP_GREATER: match = convResult > s.buffer[s.chan];
            CMP_INSIDE: begin
                match = (convResult >= thrLow) && (convResult <= thrHigh);
            end
            CMP_OUTSIDE: begin
                match = (convResult < thrLow) || (convResult > thrHigh);
            end
            default: match = 1'b0;
        endcase
        case (wrMode)
            WR_LEGACY: store = 1'b1;
            WR_SAVE_MATCH: store = match;
            WR_COMPARE_ONLY: store = 1'b0;
            default: store = 1'b0;
        endcase
    end

    always_comb begin
        rdWord = 32'h00000000;
        if (s.busAddr[BUF_SPACE_BIT]) begin
            rdWord = {20'h00000, s.buffer[s.busAddr[6:2]]};
        end else begin
            case (s.busAddr)
                ADDR_CON5: rdWord = {16'h0000, s.con5};
                ADDR_SAMPLE: rdWord = {16'h0000, s.sample};
                ADDR_HIT_HIGH: rdWord = {16'h0000, s.hit[31:16]};
                ADDR_HIT_LOW: rdWord = {16'h0000, s.hit[15:0]};
                ADDR_SCAN_HIGH: rdWord = {16'h0000, s.scan[31:16]};
                ADDR_SCAN_LOW: rdWord = {16'h0000, s.scan[15:0]};
                ADDR_LINK_CFG: begin
                    rdWord = {28'h0000000, s.pref, s.altSel, s.convOn};
                end
                ADDR_STATUS: begin
                    rdWord = {19'h00000, s.chan, 5'h00, s.altPhase,
                              s.aux.lowPower, s.fsm != ST_IDLE};
                end
                default: rdWord = 32'h00000000;
            endcase
        end
    end

    // The converter counts as active while enabled and either busy or not powered down.
    assign active = s.convOn && ((s.fsm != ST_IDLE) || !s.aux.lowPower);

    always_comb begin
        next_s = s;
        next_s.convStart = 1'b0;
        next_s.irq = 1'b0;
        next_s.result.we = 1'b0;
        hitSet = 32'h00000000;

        next_s.aux.chargeUnit = s.con5[CHARGE_REQ_BIT] && active;
        next_s.aux.bandgap = s.con5[BANDGAP_REQ_BIT] && active;
        next_s.aux.regulator = s.con5[REGULATOR_REQ_BIT] && active;
        if (!s.con5[LOW_POWER_BIT]) begin
            next_s.aux.lowPower = 1'b0;
        end

        case (s.fsm)
            ST_IDLE: begin
                if (s.convOn && convTrigger) begin
                    if (s.con5[SCAN_EN_BIT]) begin
                        if (firstChan[5]) begin
                            next_s.chan = firstChan[4:0];
                            next_s.posSel = firstChan[4:0];
                            next_s.negSel = s.sample[A_NEG_LSB +: 3];
                            next_s.autoRun = 1'b1;
                            next_s.scanMatch = 1'b0;
                            next_s.aux.lowPower = 1'b0;
                            next_s.fsm = ST_ISSUE;
                        end
                    end else begin
                        next_s.autoRun = 1'b0;
                        next_s.fsm = ST_ISSUE;
                        if (s.altSel && s.altPhase) begin
                            next_s.chan = s.sample[B_POS_LSB +: 5];
                            next_s.posSel = s.sample[B_POS_LSB +: 5];
                            next_s.negSel = s.sample[B_NEG_LSB +: 3];
                        end else begin
                            next_s.chan = s.sample[A_POS_LSB +: 5];
                            next_s.posSel = s.sample[A_POS_LSB +: 5];
                            next_s.negSel = s.sample[A_NEG_LSB +: 3];
                        end
                    end
                end
            end
            ST_ISSUE: begin
                next_s.convStart = 1'b1;
                next_s.convReq.posSel = s.posSel;
                next_s.convReq.negSel = s.negSel;
                next_s.convReq.negGround = s.negSel == NEG_GROUND;
                // Codes above input 15 other than band-gap and the two rails connect nothing.
                next_s.convReq.posFloating = (s.posSel > POS_LAST_INPUT)
                    && (s.posSel != POS_BANDGAP)
                    && (s.posSel != POS_LOWER_GUARD)
                    && (s.posSel != POS_UPPER_GUARD);
                next_s.convReq.posBandgap = s.posSel == POS_BANDGAP;
                next_s.convReq.refSel = s.pref;
                next_s.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (!s.convOn) begin
                    next_s.fsm = ST_IDLE;
                end else if (convDone) begin
                    if (match) begin
                        hitSet[s.chan] = 1'b1;
                        next_s.scanMatch = 1'b1;
                        if (intMode == INT_MATCH) begin
                            next_s.irq = 1'b1;
                        end
                    end
                    if (store) begin
                        next_s.buffer[s.chan] = convResult;
                        next_s.result.we = 1'b1;
                        next_s.result.channel = s.chan;
                        next_s.result.data = convResult;
                        if (cmpMode == CMP_OUTSIDE) begin
                            hitSet[s.chan] = 1'b1;
                        end
                    end
                    if (s.autoRun) begin
                        if (followChan[5]) begin
                            next_s.chan = followChan[4:0];
                            next_s.posSel = followChan[4:0];
                            next_s.fsm = ST_ISSUE;
                        end else begin
                            next_s.fsm = ST_FINISH;
                        end
                    end else begin
                        next_s.altPhase = s.altSel && !s.altPhase;
                        next_s.fsm = ST_IDLE;
                    end
                end
            end
            ST_FINISH: begin
                next_s.aux.lowPower = s.con5[LOW_POWER_BIT];
                next_s.autoRun = 1'b0;
                if (intMode == INT_SEQ_DONE) begin
                    next_s.irq = 1'b1;
                end
                if ((intMode == INT_MATCH_AND_DONE) && s.scanMatch) begin
                    next_s.irq = 1'b1;
                end
                next_s.fsm = ST_IDLE;
            end
            default: next_s.fsm = ST_IDLE;
        endcase

        // Bus: one wait state, then the data phase completes.
        hitKeep = s.hit;
        if (s.busPend) begin
            next_s.busPend = 1'b0;
            next_s.hreadyout = 1'b1;
            next_s.hrdata = rdWord;
            if (s.busWrite) begin
                if (s.busAddr[BUF_SPACE_BIT]) begin
                    if (!s.convOn) begin
                        next_s.buffer[s.busAddr[6:2]] = hwdata[11:0];
                    end
                end else begin
                    case (s.busAddr)
                        ADDR_CON5: begin
                            next_s.con5 = hwdata[15:0] & CON5_WRITABLE;
                        end
                        ADDR_SAMPLE: next_s.sample = hwdata[15:0];
                        ADDR_HIT_HIGH: begin
                            hitKeep[31:16] = s.hit[31:16] & hwdata[15:0];
                        end
                        ADDR_HIT_LOW: begin
                            hitKeep[15:0] = s.hit[15:0] & hwdata[15:0];
                        end
                        ADDR_SCAN_HIGH: begin
                            next_s.scan[31:16] =
                                hwdata[15:0] & SCAN_IMPL[31:16];
                        end
                        ADDR_SCAN_LOW: begin
                            next_s.scan[15:0] =
                                hwdata[15:0] & SCAN_IMPL[15:0];
                        end
                        ADDR_LINK_CFG: begin
                            next_s.convOn = hwdata[CONV_ON_BIT];
                            next_s.altSel = hwdata[ALT_SEL_BIT];
                            next_s.pref = hwdata[PREF_LSB +: 2];
                        end
                        // Status and unmapped offsets drop writes quietly.
                        default: begin
                        end
                    endcase
                end
            end
        end else if (hsel && htrans[1] && hready) begin
            next_s.busPend = 1'b1;
            next_s.busWrite = hwrite;
            next_s.busAddr = haddr[7:0];
            next_s.hreadyout = 1'b0;
        end
        // A hit raised in the cycle of a clearing write survives it.
        next_s.hit = (hitKeep | hitSet) & HIT_IMPL;
        if (!next_s.altSel) begin
            next_s.altPhase = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
            s.con5 <= CON5_RESET;
            s.sample <= SAMPLE_RESET;
            s.hit <= HIT_RESET;
            s.scan <= SCAN_RESET;
            s.fsm <= ST_IDLE;
            s.hreadyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.hreadyout;
    // Every transfer completes with OKAY.
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign convStart = s.convStart;
    assign convReq = s.convReq;
    assign resultOut = s.result;
    assign scanIrq = s.irq;
    assign auxReq = s.aux;

endmodule

`default_nettype wire
